//--- rtl/pmi_regs.sv
// Per-port media mode, transmit shaping and masked interrupt register group.
// Function
// R1 - Bit 12 selects SGMII or 1000BASE-X MAC
// R2 - Bit 11 prefers copper or fiber medium
// R3 - Three-bit field selects media operating mode
// R4 - Software sets global select before fiber modes
// R5 - Override forces SerDes, copper or normal sensing
// R6 - Mode bits apply only at software reset
// R7 - Mode bit reads show applied mode
// R8 - Super-sticky fields survive every software reset
// R9 - Sticky fields reset unless sticky enable set
// R10 - Edge-rate field from slowest to fastest
// R11 - Jumbo field sets maximum packet length
// R12 - Fifteen source mask bits, reset to zero
// R13 - Pin enable lets pin follow summary
// R14 - Clearing pin enable leaves status untouched
// R15 - Software reads status before enabling pin
// R16 - Status read clears all set bits
// R17 - Bit 15 summary, bits 14:0 sources
// R18 - Speed and duplex events need autonegotiation
// R19 - Downshift event needs full advertisement
// R20 - No receive-error event during carrier extension
// R21 - Summary set by masked source, read-clears
`default_nettype none
module pmi_regs (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        soft_reset,
  input  wire logic        sticky_reset_enable,
  input  wire logic [1:0]  global_media_interface_select,
  input  wire logic        autoneg_enable,
  input  wire logic [3:0]  adv_abilities,
  input  wire logic [14:0] event_pulse,
  input  wire logic        rx_err_carrier_ext,
  output logic             mac_if_1000x,
  output logic             mac_if_valid,
  output logic             automatic_media_sense_copper_pref,
  output logic             automatic_media_sense_pref_valid,
  output pmi_pkg::pmi_media_mode_type media_mode,
  output logic             media_mode_valid,
  output logic [1:0]       automatic_media_sense_override,
  output logic             far_end_loopback,
  output logic [2:0]       edge_rate,
  output logic             reduced_power,
  output logic [1:0]       jumbo_mode,
  output logic             connector_loopback,
  output logic             interrupt_output_pin_out,
  output logic             interrupt_output_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  logic        pend_mac_if;
  logic        pend_ams_pref;
  logic [2:0]  pend_media;
  logic [1:0]  pend_ovr;
  logic [14:0] mask;
  logic        pin_enable;
  logic [14:0] flags;
  logic        summary;
  logic [14:0] qualified;
  logic [14:0] next_flags;
  logic        wr_media;
  logic        wr_shape;
  logic        wr_mask;
  logic        rd_flags;

  assign wr_media = clk_en && reg_wr && reg_addr == pmi_pkg::ADDR_MEDIA_MODE;
  assign wr_shape = clk_en && reg_wr && reg_addr == pmi_pkg::ADDR_TX_SHAPE;
  assign wr_mask  = clk_en && reg_wr && reg_addr == pmi_pkg::ADDR_IRQ_MASK;
  assign rd_flags = clk_en && reg_rd && reg_addr == pmi_pkg::ADDR_IRQ_FLAGS;

  ////////////////////////////////////////////////////////////////////////////
  // Written mode values wait in shadow flops; the active copy changes only on a software reset.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pend_mac_if   <= 1'b0;
      pend_ams_pref <= 1'b0;
      pend_media    <= pmi_pkg::PMI_MEDIA_COPPER;
    end else if (wr_media) begin
      pend_mac_if   <= reg_wdata[pmi_pkg::MAC_IF_BIT];
      pend_ams_pref <= reg_wdata[pmi_pkg::AMS_PREF_BIT];
      pend_media    <= reg_wdata[pmi_pkg::MEDIA_MODE_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mac_if_1000x                      <= 1'b0;
      automatic_media_sense_copper_pref <= 1'b0;
      media_mode                        <= pmi_pkg::PMI_MEDIA_COPPER;
    end else if (clk_en && soft_reset) begin
      // Super-sticky: the soft reset loads the pending choice and never restores defaults.
      mac_if_1000x                      <= pend_mac_if; // [R6] [R8] [R1]
      automatic_media_sense_copper_pref <= pend_ams_pref; // [R6] [R8] [R2]
      media_mode                        <= pmi_pkg::pmi_media_mode_type'(pend_media); // [R6] [R8] [R3]
    end
  end

  // The override field is not among the applied mode bits, so it acts at once.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pend_ovr <= pmi_pkg::AMS_OVR_RST;
      far_end_loopback <= 1'b0;
    end else if (clk_en && soft_reset) begin
      // Far-end loopback is neither sticky nor super-sticky, so a soft reset drops it like the connector loopback.
      far_end_loopback <= 1'b0;
    end else if (wr_media) begin
      pend_ovr         <= reg_wdata[pmi_pkg::AMS_OVR_LSB +: 2];
      far_end_loopback <= reg_wdata[pmi_pkg::FAR_LOOP_BIT];
    end
  end

  always_comb begin
    automatic_media_sense_override = pend_ovr; // [R5]
    if (pend_ovr == 2'h3) begin
      automatic_media_sense_override = pmi_pkg::AMS_OVR_RST;
    end
  end

  assign mac_if_valid                     = global_media_interface_select == pmi_pkg::GMS_SERDES_MAC; // [R1]
  assign automatic_media_sense_pref_valid = global_media_interface_select == pmi_pkg::GMS_FIBER_MEDIA; // [R2]
  // Copper-only mode is valid in any global setting; fiber modes need the fiber setting.
  assign media_mode_valid = media_mode == pmi_pkg::PMI_MEDIA_COPPER ||
                            global_media_interface_select == pmi_pkg::GMS_FIBER_MEDIA; // [R4] [R3]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      edge_rate          <= pmi_pkg::EDGE_RATE_RST;
      reduced_power      <= 1'b0;
      jumbo_mode         <= pmi_pkg::JUMBO_RST;
      connector_loopback <= 1'b0;
    end else if (clk_en && soft_reset) begin
      connector_loopback <= 1'b0;
      if (!sticky_reset_enable) begin
        edge_rate     <= pmi_pkg::EDGE_RATE_RST; // [R9]
        reduced_power <= 1'b0;
        jumbo_mode    <= pmi_pkg::JUMBO_RST;
      end
    end else if (wr_shape) begin
      edge_rate          <= reg_wdata[pmi_pkg::EDGE_RATE_LSB +: 3]; // [R10]
      reduced_power      <= reg_wdata[pmi_pkg::REDUCED_PWR_BIT];
      jumbo_mode         <= reg_wdata[pmi_pkg::JUMBO_LSB +: 2]; // [R11]
      connector_loopback <= reg_wdata[pmi_pkg::CONN_LOOP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mask       <= pmi_pkg::MASK_RST; // [R12]
      pin_enable <= 1'b0;
    end else if (clk_en && soft_reset) begin
      if (!sticky_reset_enable) begin
        mask       <= pmi_pkg::MASK_RST; // [R9]
        pin_enable <= 1'b0;
      end
    end else if (wr_mask) begin
      mask       <= reg_wdata[pmi_pkg::NUM_SOURCES-1:0]; // [R12]
      pin_enable <= reg_wdata[pmi_pkg::PIN_ENABLE_BIT]; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events are gated by their mask and their enabling conditions before they can latch.
  genvar gi;
  generate
    for (gi = 0; gi < pmi_pkg::NUM_SOURCES; gi++) begin : g_src
      logic allow;
      if (gi == pmi_pkg::SRC_SPEED || gi == pmi_pkg::SRC_FDX) begin : g_an
        assign allow = autoneg_enable; // [R18]
      end else if (gi == pmi_pkg::SRC_DOWNSHIFT) begin : g_ds
        assign allow = adv_abilities == pmi_pkg::ADV_DOWNSHIFT_ALL; // [R19]
      end else if (gi == pmi_pkg::SRC_RX_ERR) begin : g_rx
        assign allow = !rx_err_carrier_ext; // [R20]
      end else begin : g_plain
        assign allow = 1'b1;
      end
      assign qualified[gi] = event_pulse[gi] && mask[gi] && allow; // [R12]
      // A new event in the read cycle survives the clear, so it is never lost.
      assign next_flags[gi] = qualified[gi] || (flags[gi] && !rd_flags); // [R16]
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags   <= '0;
      summary <= 1'b0;
    end else if (clk_en) begin
      flags   <= next_flags; // [R16] [R17]
      summary <= (|qualified) || (summary && !rd_flags); // [R21] [R17]
    end
  end

  // Open-drain pin: the pin enable gates only the pin, never the flags.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      interrupt_output_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      interrupt_output_pin_oe_n <= !(pin_enable && (|next_flags)); // [R13] [R14]
    end
  end
  assign interrupt_output_pin_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    reg_rdata = 16'h0000;
    case (reg_addr)
      pmi_pkg::ADDR_MEDIA_MODE: begin
        reg_rdata = {pmi_pkg::MEDIA_RESERVED_RST, mac_if_1000x, automatic_media_sense_copper_pref,
                     media_mode, pend_ovr, 2'h0, far_end_loopback, 3'h0}; // [R7]
      end
      pmi_pkg::ADDR_TX_SHAPE: begin
        reg_rdata = {edge_rate, reduced_power, 6'h00, jumbo_mode, 3'h0, connector_loopback};
      end
      pmi_pkg::ADDR_IRQ_MASK: begin
        reg_rdata = {pin_enable, mask};
      end
      pmi_pkg::ADDR_IRQ_FLAGS: begin
        reg_rdata = {summary, flags}; // [R17]
      end
      default: begin
        reg_rdata = 16'h0000;
      end
    endcase
  end

endmodule
`default_nettype wire

//--- pkg/pmi_pkg.sv
// Package holding register offsets, field positions and reset values of the mode and interrupt register group.
`default_nettype none
package pmi_pkg;
  localparam logic [4:0]  ADDR_MEDIA_MODE   = 5'h17;
  localparam logic [4:0]  ADDR_TX_SHAPE     = 5'h18;
  localparam logic [4:0]  ADDR_IRQ_MASK     = 5'h19;
  localparam logic [4:0]  ADDR_IRQ_FLAGS    = 5'h1A;
  localparam int          MAC_IF_BIT        = 12;
  localparam int          AMS_PREF_BIT      = 11;
  localparam int          MEDIA_MODE_LSB    = 8;
  localparam int          AMS_OVR_LSB       = 6;
  localparam int          FAR_LOOP_BIT      = 3;
  localparam int          EDGE_RATE_LSB     = 13;
  localparam int          REDUCED_PWR_BIT   = 12;
  localparam int          JUMBO_LSB         = 4;
  localparam int          CONN_LOOP_BIT     = 0;
  localparam int          PIN_ENABLE_BIT    = 15;
  localparam int          SRC_SPEED         = 14;
  localparam int          SRC_FDX           = 12;
  localparam int          SRC_DOWNSHIFT     = 2;
  localparam int          SRC_RX_ERR        = 0;
  localparam int          NUM_SOURCES       = 15;
  localparam logic [2:0]  MEDIA_RESERVED_RST = 3'h6;
  localparam logic [2:0]  EDGE_RATE_RST     = 3'h0;
  localparam logic [1:0]  JUMBO_RST         = 2'h0;
  localparam logic [1:0]  AMS_OVR_RST       = 2'h0;
  localparam logic [14:0] MASK_RST          = 15'h0000;
  localparam logic [3:0]  ADV_DOWNSHIFT_ALL = 4'hF;
  localparam logic [1:0]  GMS_SERDES_MAC    = 2'h1;
  localparam logic [1:0]  GMS_FIBER_MEDIA   = 2'h2;
  typedef enum logic [2:0] {
    PMI_MEDIA_COPPER      = 3'h0,
    PMI_MEDIA_FIBER_PT    = 3'h1,
    PMI_MEDIA_FIBER_1000X = 3'h2,
    PMI_MEDIA_FIBER_100FX = 3'h3,
    PMI_MEDIA_AMS         = 3'h4,
    PMI_MEDIA_AMS_PT      = 3'h5,
    PMI_MEDIA_AMS_1000X   = 3'h6,
    PMI_MEDIA_AMS_100FX   = 3'h7
  } pmi_media_mode_type;
endpackage
`default_nettype wire

//--- verif/pmi_regs_properties.sv
// Checker watching the ports of the mode and interrupt register group.
`default_nettype none
module pmi_regs_properties (
  input wire logic                        ref_clk,
  input wire logic                        rstn,
  input wire logic                        clk_en,
  input wire logic [4:0]                  reg_addr,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [15:0]                 reg_rdata,
  input wire logic                        soft_reset,
  input wire logic                        autoneg_enable,
  input wire logic [3:0]                  adv_abilities,
  input wire logic [14:0]                 event_pulse,
  input wire logic                        rx_err_carrier_ext,
  input wire pmi_pkg::pmi_media_mode_type media_mode,
  input wire logic                        interrupt_output_pin_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A gated event must leave a quiet pin quiet.
  property p_quiet(logic cause);
    clk_en && !reg_wr && !reg_rd && interrupt_output_pin_oe_n && cause |=> interrupt_output_pin_oe_n;
  endproperty
  a_mode_held: assert property ($changed(media_mode) |-> $past(soft_reset))
    else $error("mode changed without soft reset");
  a_mode_readback: assert property (reg_addr == 5'h17 |-> reg_rdata[10:8] == media_mode)
    else $error("mode read differs from applied mode");
  a_read_clears: assert property (clk_en && reg_rd && reg_addr == 5'h1A && event_pulse == 15'h0000
    |=> interrupt_output_pin_oe_n)
    else $error("pin held after flag read");
  a_pin_summary: assert property (reg_addr == 5'h1A && !interrupt_output_pin_oe_n |-> reg_rdata[15])
    else $error("pin asserted without summary");
  a_summary_sources: assert property (reg_addr == 5'h1A |-> reg_rdata[15] == (|reg_rdata[14:0]))
    else $error("summary disagrees with sources");
  a_speed_gated: assert property (p_quiet(event_pulse == 15'h4000 && !autoneg_enable))
    else $error("speed event without autonegotiation");
  a_shift_gated: assert property (p_quiet(event_pulse == 15'h0004 && adv_abilities != 4'hF))
    else $error("downshift event without advertisement");
  a_rxerr_gated: assert property (p_quiet(event_pulse == 15'h0001 && rx_err_carrier_ext))
    else $error("receive error event during extension");
  cover property (soft_reset && clk_en);
  cover property (!interrupt_output_pin_oe_n);
  cover property (reg_rd && reg_addr == 5'h1A);
endmodule
bind pmi_regs pmi_regs_properties u_props (.ref_clk, .rstn, .clk_en, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .soft_reset, .autoneg_enable, .adv_abilities, .event_pulse, .rx_err_carrier_ext,
  .media_mode, .interrupt_output_pin_oe_n);
`default_nettype wire

//--- verif/pmi_mgmt_model.sv
// Management station model issuing single-word register writes and reads.
`default_nettype none
module pmi_mgmt_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  output var logic  [4:0]  reg_addr,
  output var logic         reg_wr,
  output var logic         reg_rd,
  output var logic  [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read data is taken at the edge that ends the read, before that edge clears the flags.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    d = reg_rdata;
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the mode and interrupt register group.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        ref_clk = 1'b0;
  logic                        rstn = 1'b0;
  logic                        soft_reset = 1'b0;
  logic                        sticky_reset_enable = 1'b0;
  logic                        autoneg_enable = 1'b0;
  logic                        rx_err_carrier_ext = 1'b0;
  logic                        mac_if_1000x, media_mode_valid, interrupt_output_pin_oe_n, reg_wr, reg_rd;
  logic [3:0]                  adv_abilities = 4'hF;
  logic [14:0]                 event_pulse = 15'h0000;
  logic [4:0]                  reg_addr;
  logic [15:0]                 reg_wdata, reg_rdata;
  logic [2:0]                  edge_rate;
  pmi_pkg::pmi_media_mode_type media_mode;
  int                          err_count = 0;
  int                          comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  pmi_mgmt_model mgmt (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  pmi_regs uut (.ref_clk, .rstn, .clk_en(1'b1), .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .soft_reset, .sticky_reset_enable, .global_media_interface_select(2'h2), .autoneg_enable,
    .adv_abilities, .event_pulse, .rx_err_carrier_ext, .mac_if_1000x, .mac_if_valid(),
    .automatic_media_sense_copper_pref(), .automatic_media_sense_pref_valid(), .media_mode,
    .media_mode_valid, .automatic_media_sense_override(), .far_end_loopback(), .edge_rate,
    .reduced_power(), .jumbo_mode(), .connector_loopback(), .interrupt_output_pin_out(),
    .interrupt_output_pin_oe_n);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    mgmt.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic sr();
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    #1;
  endtask
  task automatic ev(input logic [14:0] v);
    @(posedge ref_clk);
    event_pulse <= v;
    @(posedge ref_clk);
    event_pulse <= 15'h0000;
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(5'h17, 16'hC000);
    rchk(5'h18, 16'h0000);
    rchk(5'h19, 16'h0000);
    rchk(5'h1A, 16'h0000);
    rchk(5'h10, 16'h0000);
  endtask
  task automatic t_mode();
    logic [15:0] d;
    mgmt.wr(5'h17, 16'h1B48);
    rchk(5'h17, 16'hC048);
    sr();
    mgmt.rd(5'h17, d);
    chk("mode reg", 16'hDB00, d & 16'hFF08);
    chk("mac", 16'h1, mac_if_1000x);
    for (int m = 0; m < 8; m++) begin
      mgmt.wr(5'h17, {5'h00, m[2:0], 8'h00});
      sr();
      chk("mode", 16'(m), 16'(media_mode));
      chk("valid", 16'h1, media_mode_valid);
    end
  endtask
  task automatic t_sticky();
    mgmt.wr(5'h19, 16'h7FFF);
    mgmt.wr(5'h18, 16'h7011);
    rchk(5'h18, 16'h7011);
    chk("edge", 16'h3, edge_rate);
    sticky_reset_enable <= 1'b1;
    sr();
    rchk(5'h19, 16'h7FFF);
    rchk(5'h18, 16'h7010);
    sticky_reset_enable <= 1'b0;
    sr();
    rchk(5'h19, 16'h0000);
    rchk(5'h18, 16'h0000);
    rchk(5'h17, 16'hC700);
  endtask
  task automatic t_irq();
    mgmt.wr(5'h19, 16'h8001);
    rchk(5'h1A, 16'h0000);
    rx_err_carrier_ext <= 1'b1;
    ev(15'h0001);
    ev(15'h0002);
    chk("pin", 16'h1, interrupt_output_pin_oe_n);
    rx_err_carrier_ext <= 1'b0;
    ev(15'h0001);
    chk("pin", 16'h0, interrupt_output_pin_oe_n);
    mgmt.wr(5'h1A, 16'h0000);
    mgmt.wr(5'h19, 16'h0001);
    rchk(5'h19, 16'h0001);
    chk("pin", 16'h1, interrupt_output_pin_oe_n);
    rchk(5'h1A, 16'h8001);
    rchk(5'h1A, 16'h0000);
    mgmt.wr(5'h19, 16'hC004);
    adv_abilities <= 4'h7;
    ev(15'h4000);
    ev(15'h0004);
    rchk(5'h1A, 16'h0000);
    autoneg_enable <= 1'b1;
    adv_abilities <= 4'hF;
    ev(15'h4004);
    chk("pin", 16'h0, interrupt_output_pin_oe_n);
    rchk(5'h1A, 16'hC004);
    rchk(5'h1A, 16'h0000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_mode();
    t_sticky();
    t_irq();
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
